// ===== bab_host_ctrl.sv
// Purpose: Bus module that masters block reads and writes and requests interrupts
// Assumes: Processor owns arbitration and heads both grant chains
// Notes:   All pins pass two flops before use; drivers only pull low
`timescale 1ns/1ps
module bab_host_ctrl #(
    parameter int          TMO_CYCLES = bab_pkg::TMO_CYC,
    parameter logic [15:0] INT_VECTOR = bab_pkg::VECTOR_DEF
) (
    input  wire logic                 MCLK,
    input  wire logic                 RST,
    input  wire bab_pkg::bab_bus_in_t BUS_IN,
    output bab_pkg::bab_bus_out_t     BUS_OUT,
    output logic                      IAK_CHAIN_OUT_N,
    output logic                      DMG_CHAIN_OUT_N,
    input  wire logic                 CMD_VALID,
    output logic                      CMD_READY,
    input  wire bab_pkg::bab_cmd_t    CMD,
    input  wire logic [15:0]          WR_DATA,
    input  wire logic                 WR_VALID,
    output logic                      WR_READY,
    output logic [15:0]               RD_DATA,
    output logic                      RD_VALID,
    output logic                      DONE,
    output logic                      TIMEOUT_ERR,
    input  wire logic                 IRQ_REQ,
    output logic                      IRQ_PENDING
);
    import bab_pkg::*;

    typedef enum logic [3:0] {
        IDLE, REQ, GRANT, ADDR, ASYNC, DATA, XFER, XEND, FINISH, FAIL
    } bab_state_t;

    localparam logic [1:0] SETTLE = 2'(SETTLE_CYC);

    bab_state_t       state_reg;
    bab_state_t       state_next;
    bab_bus_in_t      pins_s;
    bab_bus_in_t      bus_a;
    bab_cmd_t         cmd_reg;
    logic [CNT_W-1:0] words_left_reg;
    logic [1:0]       settle_reg;
    logic [15:0]      wdata_reg;
    logic [DAL_W-1:0] dal_drv_reg;
    logic             sync_reg;
    logic             din_reg;
    logic             dout_reg;
    logic             bs7_reg;
    logic             wtbt_reg;
    logic             dmr_reg;
    logic             sack_reg;
    logic             irq_pend_reg;
    logic             vec_reg;
    logic             vec_next;
    logic             tmo_expired;
    logic             waiting;

    function automatic logic in_cycle(input bab_state_t s);
        return (s == ASYNC) || (s == DATA) || (s == XFER) || (s == XEND);
    endfunction : in_cycle

    // Pin synchronisers
    bab_sync #(
        .WIDTH ($bits(bab_bus_in_t))
    ) u_sync (
        .clk      (MCLK),
        .rst      (RST),
        .async_in (BUS_IN),
        .sync_out (pins_s)
    );

    // Low on the pin means asserted
    assign bus_a = bab_bus_in_t'(~pins_s);

    assign waiting = (state_reg == XFER) || (state_reg == XEND);

    // Reply watchdog
    bab_timeout #(
        .LIMIT (TMO_CYCLES)
    ) u_tmo (
        .clk     (MCLK),
        .rst     (RST),
        .run     (waiting),
        .restart (state_next != state_reg),
        .expired (tmo_expired)
    );

    // Master sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IDLE:   if (CMD_VALID) state_next = REQ;
            REQ:    if (bus_a.dmg_in) state_next = GRANT;
            GRANT:  if (!bus_a.sync && !bus_a.rply) state_next = ADDR;
            ADDR:   if (settle_reg == SETTLE) state_next = ASYNC;
            ASYNC:  state_next = DATA;
            DATA:   if (!cmd_reg.write || WR_VALID) state_next = XFER;
            XFER: begin
                if (bus_a.rply) state_next = XEND;
                else if (tmo_expired) state_next = FAIL;
            end
            XEND: begin
                if (!bus_a.rply) begin
                    state_next = (words_left_reg == '0) ? FINISH : DATA;
                end else if (tmo_expired) begin
                    state_next = FAIL;
                end
            end
            FINISH: state_next = IDLE;
            FAIL:   state_next = IDLE;
            default: state_next = IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST || bus_a.init) begin
            state_reg <= IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Command capture and word counting
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cmd_reg        <= '0;
            words_left_reg <= '0;
        end else if (state_reg == IDLE && CMD_VALID) begin
            cmd_reg        <= CMD;
            words_left_reg <= CMD.words_m1;
        end else if (state_reg == XEND && !bus_a.rply && words_left_reg != '0) begin
            words_left_reg <= words_left_reg - CNT_W'(1);
        end
    end

    // Address settle time before sync
    always_ff @(posedge MCLK) begin
        if (RST || state_reg != ADDR) begin
            settle_reg <= '0;
        end else if (settle_reg != SETTLE) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    // Write data capture
    always_ff @(posedge MCLK) begin
        if (RST) begin
            wdata_reg <= '0;
        end else if (WR_READY && WR_VALID) begin
            wdata_reg <= WR_DATA;
        end
    end

    // Read data capture
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RD_DATA  <= '0;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= 1'b0;
            if (state_reg == XFER && bus_a.rply && !cmd_reg.write) begin
                RD_DATA  <= bus_a.dal[15:0];
                RD_VALID <= 1'b1;
            end
        end
    end

    // Completion pulses
    always_ff @(posedge MCLK) begin
        if (RST) begin
            DONE        <= 1'b0;
            TIMEOUT_ERR <= 1'b0;
        end else begin
            DONE        <= state_reg == FINISH;
            TIMEOUT_ERR <= state_reg == FAIL;
        end
    end

    // Control line drivers, set from the next state
    always_ff @(posedge MCLK) begin
        if (RST || bus_a.init) begin
            dmr_reg  <= 1'b0;
            sack_reg <= 1'b0;
            sync_reg <= 1'b0;
            din_reg  <= 1'b0;
            dout_reg <= 1'b0;
            bs7_reg  <= 1'b0;
            wtbt_reg <= 1'b0;
        end else begin
            dmr_reg  <= state_next == REQ;
            sack_reg <= (state_next != IDLE) && (state_next != REQ) && (state_next != FAIL);
            sync_reg <= in_cycle(state_next);
            din_reg  <= (state_next == XFER) && !cmd_reg.write;
            dout_reg <= (state_next == XFER) && cmd_reg.write;
            bs7_reg  <= (state_next == ADDR || state_next == ASYNC) && cmd_reg.io_page;
            wtbt_reg <= (state_next == ADDR || state_next == ASYNC) && cmd_reg.write;
        end
    end

    // Address or data on the shared lines
    always_ff @(posedge MCLK) begin
        if (RST || bus_a.init) begin
            dal_drv_reg <= '0;
        end else if (vec_next) begin
            dal_drv_reg <= DAL_W'(INT_VECTOR);
        end else if (state_next == ADDR || state_next == ASYNC) begin
            dal_drv_reg <= cmd_reg.addr;
        end else if ((state_next == XFER || state_next == XEND) && cmd_reg.write) begin
            dal_drv_reg <= DAL_W'(state_reg == DATA ? WR_DATA : wdata_reg);
        end else begin
            dal_drv_reg <= '0;
        end
    end

    // Interrupt request and vector reply
    always_comb begin
        vec_next = vec_reg;
        if (!vec_reg && irq_pend_reg && bus_a.iak_in && bus_a.din) vec_next = 1'b1;
        else if (vec_reg && !bus_a.din) vec_next = 1'b0;
    end

    always_ff @(posedge MCLK) begin
        if (RST || bus_a.init) begin
            vec_reg      <= 1'b0;
            irq_pend_reg <= 1'b0;
        end else begin
            vec_reg <= vec_next;
            if (IRQ_REQ) irq_pend_reg <= 1'b1;
            else if (vec_reg && !vec_next) irq_pend_reg <= 1'b0;
        end
    end

    // Daisy chains pass onward when not claimed
    always_ff @(posedge MCLK) begin
        if (RST) begin
            IAK_CHAIN_OUT_N <= 1'b1;
            DMG_CHAIN_OUT_N <= 1'b1;
        end else begin
            IAK_CHAIN_OUT_N <= !(bus_a.iak_in && !irq_pend_reg);
            DMG_CHAIN_OUT_N <= !(bus_a.dmg_in && state_reg == IDLE && !CMD_VALID);
        end
    end

    // Open-collector outputs, never driven high
    assign BUS_OUT.dal_out = '0;
    assign BUS_OUT.dal_oe  = dal_drv_reg;
    assign BUS_OUT.sync    = '{out: PIN_LOW, oe: sync_reg};
    assign BUS_OUT.din     = '{out: PIN_LOW, oe: din_reg};
    assign BUS_OUT.dout    = '{out: PIN_LOW, oe: dout_reg};
    assign BUS_OUT.rply    = '{out: PIN_LOW, oe: vec_reg};
    assign BUS_OUT.bs7     = '{out: PIN_LOW, oe: bs7_reg};
    assign BUS_OUT.wtbt    = '{out: PIN_LOW, oe: wtbt_reg};
    assign BUS_OUT.irq4    = '{out: PIN_LOW, oe: irq_pend_reg};
    assign BUS_OUT.dmr     = '{out: PIN_LOW, oe: dmr_reg};
    assign BUS_OUT.sack    = '{out: PIN_LOW, oe: sack_reg};

    assign CMD_READY   = (state_reg == IDLE) && !bus_a.init;
    assign WR_READY    = (state_reg == DATA) && cmd_reg.write;
    assign IRQ_PENDING = irq_pend_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_pull_low_only: assert property (
        BUS_OUT.sync.out == 1'b0 && BUS_OUT.din.out == 1'b0 && BUS_OUT.dout.out == 1'b0
        && BUS_OUT.rply.out == 1'b0 && BUS_OUT.dal_out == '0)
        else $error("bus line driven high");

    a_strobe_in_sync: assert property (
        (din_reg || dout_reg) |-> sync_reg && sack_reg)
        else $error("data strobe outside a framed cycle");

    a_timeout_abort: assert property (
        (waiting && tmo_expired && !bus_a.rply && state_reg == XFER) |=> state_reg == FAIL ##1
        (TIMEOUT_ERR && !sync_reg && !din_reg && !dout_reg))
        else $error("reply timeout did not abort the cycle");

    a_chain_passes: assert property (
        (bus_a.iak_in && !irq_pend_reg) |=> !IAK_CHAIN_OUT_N)
        else $error("unclaimed acknowledge not passed on");

    a_chain_claimed: assert property (
        irq_pend_reg && $past(irq_pend_reg) |-> IAK_CHAIN_OUT_N)
        else $error("claimed acknowledge passed on");

    a_master_granted: assert property (
        $rose(sack_reg) |-> $past(bus_a.dmg_in, 2) || $past(bus_a.dmg_in))
        else $error("select acknowledge without grant");

    a_single_address: assert property (
        (state_reg == XEND && !bus_a.rply && words_left_reg != '0) |=> state_reg == DATA
        ##1 sync_reg && !bs7_reg && !wtbt_reg)
        else $error("block word did not stay in the framed cycle");

    a_full_address: assert property (
        (state_reg == ASYNC) |-> dal_drv_reg == cmd_reg.addr && sync_reg)
        else $error("address not held when sync rises");

    a_interlock_done: assert property (
        $fell(din_reg) && !RST && !$past(bus_a.init) |-> $past(bus_a.rply) || $past(tmo_expired))
        else $error("input strobe dropped without reply");

endmodule : bab_host_ctrl

// ===== bab_pkg.sv
// Purpose: Shared constants and carrier types for the backplane bus master module
// Assumes: MCLK at 20 MHz; bus pins are open collector, low means asserted
// Notes:   Pin structs carry raw pin levels; out fields are always low when enabled
package bab_pkg;

    localparam int          DAL_W       = 22;
    localparam int          DATA_W      = 16;
    localparam int          CNT_W       = 8;
    localparam int          CLK_NS      = 50;
    localparam int          TMO_NS      = 10000;
    localparam int          TMO_CYC     = TMO_NS / CLK_NS;
    localparam int          SETTLE_CYC  = 2;
    localparam int          SYNC_STAGES = 2;
    localparam logic        PIN_LOW     = 1'b0;
    localparam logic [15:0] VECTOR_DEF  = 16'h00C0;

    // One open-collector line: level driven and its enable
    typedef struct packed {
        logic out;
        logic oe;
    } bab_oc_t;

    // Raw pin levels as seen on the backplane
    typedef struct packed {
        logic [DAL_W-1:0] dal;
        logic             sync;
        logic             din;
        logic             dout;
        logic             rply;
        logic             sack;
        logic             iak_in;
        logic             dmg_in;
        logic             init;
    } bab_bus_in_t;

    typedef struct packed {
        logic [DAL_W-1:0] dal_out;
        logic [DAL_W-1:0] dal_oe;
        bab_oc_t          sync;
        bab_oc_t          din;
        bab_oc_t          dout;
        bab_oc_t          rply;
        bab_oc_t          bs7;
        bab_oc_t          wtbt;
        bab_oc_t          irq4;
        bab_oc_t          dmr;
        bab_oc_t          sack;
    } bab_bus_out_t;

    // Block transfer request from the user side
    typedef struct packed {
        logic             write;
        logic             io_page;
        logic [DAL_W-1:0] addr;
        logic [CNT_W-1:0] words_m1;
    } bab_cmd_t;

endpackage : bab_pkg

// ===== bab_sync.sv
// Purpose: Two-stage synchroniser for asynchronous bus pins
// Assumes: Inputs change without regard to MCLK
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module bab_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Pins idle high, so reset to the negated level
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : bab_sync

// ===== bab_timeout.sv
// Purpose: Reply watchdog counting MCLK cycles while a reply is awaited
// Assumes: restart pulses on every handshake step
// Notes:   expired is a level held until run drops or restart
`timescale 1ns/1ps
module bab_timeout #(
    parameter int LIMIT = 200
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic restart,
    output logic      expired
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (rst || !run || restart) begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end else if (cnt_reg != LIM) begin
            cnt_reg <= cnt_reg + CW'(1);
            expired <= (cnt_reg + CW'(1)) == LIM;
        end
    end

endmodule : bab_timeout

// ===== bab_bus_model.sv
// Purpose: Arbiter, slave memory and interrupt reader on the far side of the bus
// Assumes: Every line has a pull-up, so a released line reads high
// Notes:   Reply delay, muting and chain holding are set by the bench
`timescale 1ns/1ps
module bab_bus_model (
    input  wire logic                  clk,
    input  wire bab_pkg::bab_bus_out_t bo,
    input  wire logic [7:0]            dly,
    input  wire logic                  mute,
    input  wire logic                  hold,
    input  wire logic                  iak_go,
    input  wire logic                  init_req,
    output bab_pkg::bab_bus_in_t       bi,
    output logic [21:0]                addr_seen,
    output logic                       bs7_seen,
    output logic                       wtbt_seen,
    output logic [15:0]                vec_seen,
    output logic [7:0]                 wr_cnt
);
    import bab_pkg::*;
    logic [15:0] mem [256];
    logic [21:0] m_dal  = '0;
    logic [7:0]  ptr    = '0;
    logic [7:0]  cnt    = '0;
    logic        m_rply = 1'b0;
    logic        m_dmg  = 1'b0;
    logic        ibusy  = 1'b0;
    logic        sync_q = 1'b0;
    logic [7:0]  wr_q   = '0;
    logic        strb;

    // Written word count starts from zero, not unknown
    assign wr_cnt = wr_q;

    function automatic logic lv(bab_oc_t p);
        return p.oe ? p.out : 1'b1;
    endfunction : lv

    // Wired lines, low wins
    assign bi.dal    = (~bo.dal_oe | bo.dal_out) & ~m_dal;
    assign bi.sync   = lv(bo.sync) & ~ibusy;
    assign bi.din    = lv(bo.din) & ~ibusy;
    assign bi.dout   = lv(bo.dout);
    assign bi.rply   = lv(bo.rply) & ~m_rply;
    assign bi.sack   = lv(bo.sack);
    assign bi.iak_in = ~(ibusy | hold);
    assign bi.dmg_in = ~m_dmg;
    assign bi.init   = ~init_req;
    assign strb      = ~lv(bo.din) | ~lv(bo.dout);

    // Grant held until select acknowledge
    always_ff @(posedge clk) begin
        m_dmg <= hold | (~lv(bo.dmr) & lv(bo.sack));
    end

    // Slave: address latch, delayed reply, release on strobe drop
    always_ff @(posedge clk) begin
        sync_q <= ~lv(bo.sync);
        if (~lv(bo.sync) && !sync_q) begin
            addr_seen <= ~bi.dal;
            bs7_seen  <= ~lv(bo.bs7);
            wtbt_seen <= ~lv(bo.wtbt);
            ptr       <= ~bi.dal[8:1];
        end
        if (strb && !m_rply && !mute) begin
            cnt <= cnt + 8'h01;
            if (cnt == dly) begin
                m_rply <= 1'b1;
                if (~lv(bo.din)) begin
                    m_dal <= {6'h00, mem[ptr]};
                end else begin
                    mem[ptr] <= ~bi.dal[15:0];
                    wr_q     <= wr_q + 8'h01;
                end
            end
        end else if (!strb) begin
            cnt <= '0;
            if (m_rply) begin
                m_rply <= 1'b0;
                m_dal  <= '0;
                ptr    <= ptr + 8'h01;
            end
        end
    end

    // Processor side vector read
    always_ff @(posedge clk) begin
        if (iak_go) begin
            ibusy <= 1'b1;
        end else if (ibusy && !bi.rply) begin
            vec_seen <= ~bi.dal[15:0];
            ibusy    <= 1'b0;
        end
    end
endmodule : bab_bus_model

// ===== tb.sv
// Purpose: Self-checking bench for the bus master module
// Assumes: Reply timeout shortened to 20 cycles
// Notes:   Far side is bab_bus_model
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module tb;
    import bab_pkg::*;
    localparam int          TMO = 20;
    localparam logic [15:0] VEC = 16'h0154;
    logic         MCLK = 1'b0;
    logic         RST = 1'b1;
    logic         CMD_VALID = 1'b0;
    bab_cmd_t     CMD = '0;
    logic [15:0]  WR_DATA = '0;
    logic         WR_VALID = 1'b0;
    logic         IRQ_REQ = 1'b0;
    bab_bus_in_t  BUS_IN;
    bab_bus_out_t BUS_OUT;
    logic         IAK_CHAIN_OUT_N, DMG_CHAIN_OUT_N, CMD_READY, WR_READY;
    logic         RD_VALID, DONE, TIMEOUT_ERR, IRQ_PENDING;
    logic [15:0]  RD_DATA, vec_seen;
    logic [7:0]   dly = 8'h03;
    logic         mute = 1'b0, hold = 1'b0, iak_go = 1'b0, init_req = 1'b0;
    logic [21:0]  addr_seen;
    logic         bs7_seen, wtbt_seen;
    logic [7:0]   wr_cnt;
    logic [15:0]  wd [8];
    logic [15:0]  rd [8];
    int           errors = 0, checks = 0;

    bab_host_ctrl #(.TMO_CYCLES(TMO), .INT_VECTOR(VEC)) uut (
        .MCLK, .RST, .BUS_IN, .BUS_OUT, .IAK_CHAIN_OUT_N, .DMG_CHAIN_OUT_N, .CMD_VALID,
        .CMD_READY, .CMD, .WR_DATA, .WR_VALID, .WR_READY, .RD_DATA, .RD_VALID, .DONE,
        .TIMEOUT_ERR, .IRQ_REQ, .IRQ_PENDING);
    bab_bus_model bus (
        .clk(MCLK), .bo(BUS_OUT), .dly, .mute, .hold, .iak_go, .init_req, .bi(BUS_IN),
        .addr_seen, .bs7_seen, .wtbt_seen, .vec_seen, .wr_cnt);

    always #25 MCLK = ~MCLK;

    task automatic give_verdict;
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic run(input logic wr, input logic iop, input logic [21:0] a, input int n,
                       output logic ok, output logic tmo, output int i);
        i = 0;
        ok = 1'b0;
        tmo = 1'b0;
        CMD_VALID <= 1'b1;
        CMD <= '{write: wr, io_page: iop, addr: a, words_m1: 8'(n - 1)};
        WR_VALID <= wr;
        WR_DATA <= wd[0];
        do @(posedge MCLK); while (CMD_READY !== 1'b1);
        CMD_VALID <= 1'b0;
        for (int k = 0; k < 3000 && !ok && !tmo; k++) begin
            @(posedge MCLK);
            if (wr && WR_VALID && WR_READY === 1'b1) begin
                i++;
                WR_DATA <= wd[i];
                WR_VALID <= (i < n);
            end
            if (RD_VALID === 1'b1) begin
                rd[i] = RD_DATA;
                i++;
            end
            ok = (DONE === 1'b1);
            tmo = (TIMEOUT_ERR === 1'b1);
        end
    endtask : run

    task automatic t_block;
        logic ok, tmo;
        int n;
        wd = '{16'h1234, 16'hA5C3, 16'h0001, 16'hFFFE, 16'h0, 16'h0, 16'h0, 16'h0};
        run(1'b1, 1'b0, 22'h3C_0100, 4, ok, tmo, n);
        `CHK("wr_done", 1'b1, ok)
        `CHK("wr_words", 8'h04, wr_cnt)
        `CHK("wr_addr", 22'h3C_0100, addr_seen)
        `CHK("wr_flag", 1'b1, wtbt_seen)
        run(1'b0, 1'b1, 22'h3C_0100, 4, ok, tmo, n);
        `CHK("rd_count", 4, n)
        for (int j = 0; j < 4; j++) `CHK("rd_data", wd[j], rd[j])
        `CHK("rd_page", 1'b1, bs7_seen)
        `CHK("rd_flag", 1'b0, wtbt_seen)
    endtask : t_block

    task automatic t_timeout;
        logic ok, tmo;
        int n;
        dly <= 8'h0A;
        run(1'b0, 1'b0, 22'h00_0102, 1, ok, tmo, n);
        `CHK("slow_ok", 1'b1, ok)
        `CHK("slow_data", wd[1], rd[0])
        mute <= 1'b1;
        run(1'b0, 1'b0, 22'h00_0100, 2, ok, tmo, n);
        `CHK("tmo_flag", 1'b1, tmo)
        `CHK("tmo_off", '0, BUS_OUT)
        mute <= 1'b0;
        dly <= 8'h00;
        run(1'b0, 1'b0, 22'h3C_0104, 1, ok, tmo, n);
        `CHK("after_tmo", wd[2], rd[0])
    endtask : t_timeout

    task automatic t_irq;
        IRQ_REQ <= 1'b1;
        @(posedge MCLK);
        IRQ_REQ <= 1'b0;
        @(posedge MCLK);
        `CHK("irq_line", 1'b1, BUS_OUT.irq4.oe)
        hold <= 1'b1;
        repeat (6) @(posedge MCLK);
        `CHK("iak_kept", 1'b1, IAK_CHAIN_OUT_N)
        `CHK("dmg_pass", 1'b0, DMG_CHAIN_OUT_N)
        hold <= 1'b0;
        repeat (6) @(posedge MCLK);
        iak_go <= 1'b1;
        @(posedge MCLK);
        iak_go <= 1'b0;
        repeat (14) @(posedge MCLK);
        `CHK("vector", VEC, vec_seen)
        `CHK("irq_clr", 1'b0, IRQ_PENDING)
        `CHK("irq_off", 1'b0, BUS_OUT.irq4.oe)
        hold <= 1'b1;
        repeat (6) @(posedge MCLK);
        `CHK("iak_pass", 1'b0, IAK_CHAIN_OUT_N)
        hold <= 1'b0;
        repeat (6) @(posedge MCLK);
        `CHK("iak_idle", 1'b1, IAK_CHAIN_OUT_N)
        `CHK("dmg_idle", 1'b1, DMG_CHAIN_OUT_N)
    endtask : t_irq

    initial begin
        #500000;
        errors++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        repeat (2) @(posedge MCLK);
        `CHK("rst_bus", '0, BUS_OUT)
        `CHK("rst_ready", 1'b1, CMD_READY)
        t_block();
        t_timeout();
        t_irq();
        init_req <= 1'b1;
        repeat (5) @(posedge MCLK);
        `CHK("init_busy", 1'b0, CMD_READY)
        init_req <= 1'b0;
        repeat (5) @(posedge MCLK);
        `CHK("init_done", 1'b1, CMD_READY)
        give_verdict();
    end
endmodule : tb
